// file: pkg/udsie_map.vh
// register map, field positions and reset values of the device status and in-irq block
`ifndef UDSIE_MAP_VH
`define UDSIE_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define UDSIE_DEVICE_LINK_STATUS_OFS  12'h0808
`define UDSIE_IN_EP_IRQ_MASK_OFS      12'h0810
`define UDSIE_ALL_ENDPOINTS_IRQ_OFS   12'h0818
`define UDSIE_IRQ_STATUS_OFS          12'h0840
`define UDSIE_IRQ_MASK_OFS            12'h0844
`define UDSIE_GLOBAL_IRQ_FLAGS_OFS    12'h0848

// ****************************************************************
// device link status fields
// ****************************************************************
`define UDSIE_FRAME_MSB        21
`define UDSIE_FRAME_LSB        8
`define UDSIE_SPEED_MSB        2
`define UDSIE_SPEED_LSB        1
`define UDSIE_SUSPEND_BIT      0
`define UDSIE_SPEED_FULL       2'h3

// ****************************************************************
// in endpoint irq mask fields
// ****************************************************************
`define UDSIE_NAK_EFF_BIT      6
`define UDSIE_TX_UNDERRUN_BIT  4
`define UDSIE_CTRL_TIMEOUT_BIT 3
`define UDSIE_EP_DISABLED_BIT  1
`define UDSIE_XFER_DONE_BIT    0
`define UDSIE_IN_MASK_WRITABLE 7'h5b
`define UDSIE_FLAG_W           7

// ****************************************************************
// block interrupt status bits
// ****************************************************************
`define UDSIE_EV_SOF_BIT       0
`define UDSIE_EV_SUSPEND_BIT   1
`define UDSIE_EV_RESUME_BIT    2
`define UDSIE_EV_ENUM_BIT      3
`define UDSIE_EV_EP_BIT        4
`define UDSIE_EV_W             5

`define UDSIE_RESET_VALUE      32'h0000_0000

`endif

// file: src/udsie_ep_summary.v
// per-endpoint or-reduction of in endpoint event flags gated by the common enable mask
`timescale 1ns/1ps
`default_nettype none

module udsie_ep_summary #(
  parameter NUM_EP = 4,
  parameter FLAG_W = 7
) (
  input  wire [NUM_EP*FLAG_W-1:0] in_endpoint_event_flags,
  input  wire [FLAG_W-1:0]        enable_mask,
  output wire [NUM_EP-1:0]        in_endpoint_irq_bits
);

  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep = ep + 1) begin : g_ep
      // a flag counts only where its enable bit is set
      assign in_endpoint_irq_bits[ep] =
        |(in_endpoint_event_flags[ep*FLAG_W +: FLAG_W] & enable_mask);
    end
  endgenerate

endmodule

`default_nettype wire

// file: src/udsie_top.v
// device status register, common in-endpoint irq enable mask and endpoint summary
//
// Overview of operation
// - Each received start-of-frame token loads its 14-bit frame number into bits 21:8 of the status register.
// - Bits 2:1 of the status register show the enumerated speed, 11 meaning full speed.
// - Bit 0 of the status register is high exactly while the device is suspended.
// - An in-endpoint event flag reaches the endpoint summary only when its common enable bit is set.
// - The in enable bits change only by software writes, never by hardware.
// - Mask bit 6 passes the nak-effective flag.
// - Mask bit 4 passes the transmit fifo underrun flag.
// - Mask bit 3 passes the control-in timeout flag.
// - Mask bit 1 passes the endpoint-disabled flag.
// - Mask bit 0 passes the transfer-finished flag.
// - A triggered in-endpoint interrupt sets bit n of the low four bits of the all-endpoints register.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "udsie_map.vh"

module udsie_top #(
  parameter NUM_EP = 4
) (
  input  wire                         clk,
  input  wire                         srst,
  // register port
  input  wire [11:0]                  reg_addr,
  input  wire [31:0]                  reg_wdata,
  input  wire                         reg_wr,
  input  wire                         reg_rd,
  output reg  [31:0]                  reg_rdata,
  // link side events
  input  wire                         sof_valid,
  input  wire [13:0]                  sof_frame_number,
  input  wire                         enum_done,
  input  wire [1:0]                   enumerated_speed,
  input  wire                         suspend_enter,
  input  wire                         suspend_exit,
  // endpoint flags, 7 bits per in endpoint
  input  wire [NUM_EP*`UDSIE_FLAG_W-1:0] in_endpoint_event_flags,
  // outputs
  output reg  [NUM_EP-1:0]            all_endpoints_irq,
  output reg                          suspend_flag,
  output reg                          irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [13:0]              frame_reg;
  reg  [1:0]               speed_reg;
  reg  [`UDSIE_FLAG_W-1:0] in_mask_reg;
  reg  [`UDSIE_EV_W-1:0]   irq_status_reg;
  reg  [`UDSIE_EV_W-1:0]   irq_mask_reg;
  reg  [`UDSIE_EV_W-1:0]   irq_status_next;
  reg  [NUM_EP-1:0]        ep_bits_prev_reg;
  reg  [31:0]              rdata_next;
  wire [NUM_EP-1:0]        in_endpoint_irq_bits;
  wire [`UDSIE_EV_W-1:0]   events;
  reg  [1:0]               link_state_reg;
  reg  [1:0]               link_state_next;
  reg  [`UDSIE_FLAG_W-1:0] in_mask_next;
  wire [`UDSIE_EV_W-1:0]   status_clear;
  wire [`UDSIE_FLAG_W-1:0] in_mask_wr_bits;

  localparam [1:0] ST_AWAKE     = 2'b01;
  localparam [1:0] ST_SUSPENDED = 2'b10;

  // ****************************************************************
  // endpoint summary
  // ****************************************************************
  udsie_ep_summary #(
    .NUM_EP (NUM_EP),
    .FLAG_W (`UDSIE_FLAG_W)
  ) u_summary (
    .in_endpoint_event_flags (in_endpoint_event_flags),
    .enable_mask             (in_mask_reg),
    .in_endpoint_irq_bits    (in_endpoint_irq_bits)
  );

  function [31:0] status_word;
    input [13:0] frame;
    input [1:0]  speed;
    input        susp;
    begin
      status_word = `UDSIE_RESET_VALUE;
      status_word[`UDSIE_FRAME_MSB:`UDSIE_FRAME_LSB] = frame;
      status_word[`UDSIE_SPEED_MSB:`UDSIE_SPEED_LSB] = speed;
      status_word[`UDSIE_SUSPEND_BIT] = susp;
    end
  endfunction

  function wr_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      wr_hit = reg_wr && (addr == ofs);
    end
  endfunction

  // ****************************************************************
  // register field helpers
  // ****************************************************************
  function in_bit_writable;
    input integer idx;
    begin
      in_bit_writable = (idx == `UDSIE_NAK_EFF_BIT) ||
                        (idx == `UDSIE_TX_UNDERRUN_BIT) ||
                        (idx == `UDSIE_CTRL_TIMEOUT_BIT) ||
                        (idx == `UDSIE_EP_DISABLED_BIT) ||
                        (idx == `UDSIE_XFER_DONE_BIT);
    end
  endfunction

  function [31:0] mask_word;
    input [`UDSIE_FLAG_W-1:0] mask;
    begin
      mask_word = `UDSIE_RESET_VALUE;
      mask_word[`UDSIE_FLAG_W-1:0] = mask;
    end
  endfunction

  function [31:0] event_word;
    input [`UDSIE_EV_W-1:0] ev;
    begin
      event_word = `UDSIE_RESET_VALUE;
      event_word[`UDSIE_EV_W-1:0] = ev;
    end
  endfunction

  function [31:0] ep_word;
    input [NUM_EP-1:0] bits;
    begin
      ep_word = `UDSIE_RESET_VALUE;
      ep_word[NUM_EP-1:0] = bits;
    end
  endfunction

  function [31:0] global_flags_word;
    input [`UDSIE_EV_W-1:0] ev;
    begin
      global_flags_word = `UDSIE_RESET_VALUE;
      global_flags_word[`UDSIE_EV_ENUM_BIT] = ev[`UDSIE_EV_ENUM_BIT];
    end
  endfunction

  // ****************************************************************
  // frame number capture
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      frame_reg <= 14'h0000;
    end else if (sof_valid) begin
      frame_reg <= sof_frame_number;
    end
  end

  // ****************************************************************
  // enumerated speed capture
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      speed_reg <= 2'h0;
    end else if (enum_done) begin
      speed_reg <= enumerated_speed;
    end
  end

  // ****************************************************************
  // suspend state machine
  // ****************************************************************
  always @* begin
    link_state_next = link_state_reg;
    case (link_state_reg)
      ST_AWAKE: begin
        if (suspend_enter) begin
          link_state_next = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        // enter wins when both pulses arrive together
        if (suspend_exit && !suspend_enter) begin
          link_state_next = ST_AWAKE;
        end
      end
      default: begin
        link_state_next = ST_AWAKE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      link_state_reg <= ST_AWAKE;
      suspend_flag   <= 1'b0;
    end else begin
      link_state_reg <= link_state_next;
      // output follows the next state so it lands with the state register, one cycle after the event
      suspend_flag   <= (link_state_next == ST_SUSPENDED);
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      in_mask_reg  <= 7'h00;
      irq_mask_reg <= 5'h00;
    end else begin
      in_mask_reg <= in_mask_next;
      if (wr_hit(reg_addr, `UDSIE_IRQ_MASK_OFS)) begin
        irq_mask_reg <= reg_wdata[`UDSIE_EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // in enable mask write path
  // ****************************************************************
  genvar mb;
  generate
    for (mb = 0; mb < `UDSIE_FLAG_W; mb = mb + 1) begin : g_in_mask
      // reserved positions never take a one
      assign in_mask_wr_bits[mb] = reg_wdata[mb] & in_bit_writable(mb);
    end
  endgenerate

  always @* begin
    in_mask_next = in_mask_reg;
    // only a software write alters the enables
    if (wr_hit(reg_addr, `UDSIE_IN_EP_IRQ_MASK_OFS)) begin
      in_mask_next = in_mask_wr_bits;
    end
  end

  // ****************************************************************
  // write-one-to-clear decode
  // ****************************************************************
  genvar cb;
  generate
    for (cb = 0; cb < `UDSIE_EV_W; cb = cb + 1) begin : g_clear
      assign status_clear[cb] = wr_hit(reg_addr, `UDSIE_IRQ_STATUS_OFS) & reg_wdata[cb];
    end
  endgenerate

  // ****************************************************************
  // summary register and interrupt
  // ****************************************************************
  assign events[`UDSIE_EV_SOF_BIT]     = sof_valid;
  assign events[`UDSIE_EV_SUSPEND_BIT] = suspend_enter & ~suspend_flag;
  assign events[`UDSIE_EV_RESUME_BIT]  = suspend_exit & ~suspend_enter & suspend_flag;
  assign events[`UDSIE_EV_ENUM_BIT]    = enum_done;
  assign events[`UDSIE_EV_EP_BIT]      = |(in_endpoint_irq_bits & ~ep_bits_prev_reg);

  // ****************************************************************
  // endpoint summary registers
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      all_endpoints_irq <= {NUM_EP{1'b0}};
      ep_bits_prev_reg  <= {NUM_EP{1'b0}};
    end else begin
      all_endpoints_irq <= in_endpoint_irq_bits;
      ep_bits_prev_reg  <= in_endpoint_irq_bits;
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  always @* begin
    irq_status_next = irq_status_reg;
    irq_status_next = irq_status_next & ~status_clear;
    // set wins over a clear in the same cycle
    irq_status_next = irq_status_next | events;
  end

  always @(posedge clk) begin
    if (srst) begin
      irq_status_reg <= 5'h00;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq            <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always @* begin
    rdata_next = `UDSIE_RESET_VALUE;
    case (reg_addr)
      `UDSIE_DEVICE_LINK_STATUS_OFS: begin
        rdata_next = status_word(frame_reg, speed_reg, suspend_flag);
      end
      `UDSIE_IN_EP_IRQ_MASK_OFS: begin
        rdata_next = mask_word(in_mask_reg);
      end
      `UDSIE_ALL_ENDPOINTS_IRQ_OFS: begin
        rdata_next = ep_word(all_endpoints_irq);
      end
      `UDSIE_IRQ_STATUS_OFS: begin
        rdata_next = event_word(irq_status_reg);
      end
      `UDSIE_IRQ_MASK_OFS: begin
        rdata_next = event_word(irq_mask_reg);
      end
      `UDSIE_GLOBAL_IRQ_FLAGS_OFS: begin
        rdata_next = global_flags_word(irq_status_reg);
      end
      default: begin
        rdata_next = `UDSIE_RESET_VALUE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= `UDSIE_RESET_VALUE;
    end else if (reg_rd) begin
      // data stand only in the cycle after the read strobe
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `UDSIE_RESET_VALUE;
    end
  end

endmodule

`default_nettype wire

// file: bench/udsie_host_model.sv
// host side model: sof tokens, enumeration and suspend signalling
`timescale 1ns/1ps
`default_nettype none
module udsie_host_model (
  input  wire logic        clk,
  output var  logic        sof_valid,
  output var  logic [13:0] sof_frame_number,
  output var  logic        enum_done,
  output var  logic [1:0]  enumerated_speed,
  output var  logic        suspend_enter,
  output var  logic        suspend_exit
);
  initial {sof_valid, sof_frame_number, enum_done, enumerated_speed} = '0;
  initial {suspend_enter, suspend_exit} = '0;
  // one-cycle event pulse: ev = {sof, enum, enter, exit}; data inverted once released
  task automatic ev(input logic [3:0] e, input logic [13:0] f);
    @(posedge clk);
    {sof_valid, enum_done, suspend_enter, suspend_exit} <= e;
    sof_frame_number <= f;
    enumerated_speed <= f[1:0];
    @(posedge clk);
    {sof_valid, enum_done, suspend_enter, suspend_exit} <= 4'h0;
    sof_frame_number <= ~f;
    enumerated_speed <= ~f[1:0];
  endtask
endmodule
`default_nettype wire

// file: bench/udsie_top_asserts.sv
// port assertions of the device status and in-irq block
`timescale 1ns/1ps
`default_nettype none
module udsie_top_asserts #(
  parameter NUM_EP = 4
) (
  input wire logic                  clk, srst, reg_wr, reg_rd, sof_valid, enum_done,
  input wire logic                  suspend_enter, suspend_exit, suspend_flag, irq,
  input wire logic [11:0]           reg_addr,
  input wire logic [31:0]           reg_wdata, reg_rdata,
  input wire logic [13:0]           sof_frame_number,
  input wire logic [1:0]            enumerated_speed,
  input wire logic [NUM_EP*7-1:0]   in_endpoint_event_flags,
  input wire logic [NUM_EP-1:0]     all_endpoints_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");
  chk_sof_capture: assert property (
    sof_valid ##1 !sof_valid ##1 (reg_rd && reg_addr == 12'h808)
    |=> reg_rdata[21:8] == $past(sof_frame_number, 3)) else $error("frame number lost");
  chk_speed_shown: assert property (
    enum_done ##4 (reg_rd && reg_addr == 12'h808)
    |=> reg_rdata[2:1] == $past(enumerated_speed, 5)) else $error("speed field wrong");
  chk_susp_set: assert property (suspend_enter |=> suspend_flag)
    else $error("suspend not entered");
  chk_susp_clear: assert property (suspend_exit && !suspend_enter |=> !suspend_flag)
    else $error("suspend not left");
  chk_susp_hold: assert property (
    !suspend_enter && !suspend_exit |=> $stable(suspend_flag)) else $error("suspend moved");
  chk_ep_quiet: assert property (
    in_endpoint_event_flags == '0 |=> all_endpoints_irq == '0) else $error("stray ep irq");
  chk_stat_rsvd: assert property (
    reg_rd && reg_addr == 12'h808 |=> reg_rdata[31:22] == '0 && reg_rdata[7:3] == '0)
    else $error("status reserved bits set");
  chk_mask_rsvd: assert property (
    reg_rd && reg_addr == 12'h810 |=> reg_rdata[31:7] == '0 && !reg_rdata[5] && !reg_rdata[2])
    else $error("mask reserved bits set");
  cover property (sof_valid ##2 reg_rd);
  cover property (suspend_enter ##1 suspend_flag);
  cover property ($rose(irq));
endmodule
bind udsie_top udsie_top_asserts #(.NUM_EP(NUM_EP)) u_chk (.clk, .srst, .reg_wr, .reg_rd,
  .sof_valid, .enum_done, .suspend_enter, .suspend_exit, .suspend_flag, .irq, .reg_addr,
  .reg_wdata, .reg_rdata, .sof_frame_number, .enumerated_speed, .in_endpoint_event_flags,
  .all_endpoints_irq);
`default_nettype wire

// file: bench/udsie_top_bench.sv
// register-level tests of the device status and in-irq block
`timescale 1ns/1ps
`default_nettype none
module udsie_top_bench;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, sof, en, s_in, s_out, susp, irq;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [13:0] frame;
  logic [1:0]  speed;
  logic [27:0] flags = '0;
  logic [3:0]  ep_irq;
  logic [6:0]  m;
  int n_mismatch = 0, compares = 0, cycles = 0, i, e;
  int pos[5] = '{6, 4, 3, 1, 0};
  always #10 clk = ~clk;
  udsie_host_model u_host (.clk(clk), .sof_valid(sof), .sof_frame_number(frame),
    .enum_done(en), .enumerated_speed(speed), .suspend_enter(s_in), .suspend_exit(s_out));
  udsie_top #(.NUM_EP(4)) u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sof_valid(sof), .sof_frame_number(frame), .enum_done(en), .enumerated_speed(speed),
    .suspend_enter(s_in), .suspend_exit(s_out), .in_endpoint_event_flags(flags),
    .all_endpoints_irq(ep_irq), .suspend_flag(susp), .irq(irq));
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("read %h", a), exp, reg_rdata);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(12'h808, 32'h0000_0000);
    rd(12'h810, 32'h0000_0000);
    wr(12'h810, 32'hffff_ffff);
    rd(12'h810, 32'h0000_005b);
    wr(12'h900, 32'hffff_ffff);
    rd(12'h900, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      e = i % 4;
      m = 7'h01 << pos[i];
      wr(12'h810, 32'h1 << pos[i]);
      flags <= 28'h1 << (7 * e + pos[i]);
      repeat (2) @(posedge clk);
      #1 chk("all_endpoints_irq", 32'h1 << e, {28'h0, ep_irq});
      rd(12'h818, 32'h1 << e);
      flags <= ~{4{m}};
      repeat (2) @(posedge clk);
      #1 chk("all_endpoints_irq", 32'h0, {28'h0, ep_irq});
    end
    @(posedge clk);
    flags <= '0;
    wr(12'h840, 32'h0000_001f);
    wr(12'h844, 32'h0000_0001);
    u_host.ev(4'h8, 14'h3fff);
    rd(12'h808, 32'h003f_ff00);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h808, 32'hffff_ffff);
    rd(12'h840, 32'h0000_0001);
    wr(12'h840, 32'h0000_0001);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wr(12'h844, 32'h0000_0000);
    u_host.ev(4'h8, 14'h1555);
    rd(12'h840, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    u_host.ev(4'h4, 14'h0003);
    rd(12'h848, 32'h0000_0008);
    rd(12'h808, 32'h0015_5506);
    u_host.ev(4'h2, 14'h0000);
    #1 chk("suspend_flag", 32'h1, {31'h0, susp});
    rd(12'h808, 32'h0015_5507);
    u_host.ev(4'h3, 14'h0000);
    #1 chk("suspend_flag", 32'h1, {31'h0, susp});
    u_host.ev(4'h1, 14'h0000);
    #1 chk("suspend_flag", 32'h0, {31'h0, susp});
    rd(12'h840, 32'h0000_000f);
    final_report();
  end
endmodule
`default_nettype wire
